// >>> pkg/cfs_pkg.sv
// Constants and types for the channel fault status register bank
//
// Functional notes
// RL1: Short-to-supply status at index 3h; bits 3..0 flag channels 4..1.
// RL2: Short-to-supply bit stays latched; clears on read once the short is gone.
// RL3: Short-to-supply bit reads 1 for fault occurred, 0 for none.
// RL4: Off-state open-load status at index 4h; bits 3..0 flag channels 4..1.
// RL5: Off-state open-load bit latches; clears on its register read once condition ends.
// RL6: Off-state open-load bit reads 1 for fault, 0 for none.
// RL7: On-state open-load status at index 5h; bits 3..0 flag channels 4..1.
// RL8: On-state open-load bit reads 1 for fault occurred, 0 for none.
// RL9: Current-limit status at index 6h, reset value 00h, flags limited channels.
// RL10: The three other status registers read 00h after reset.
// RL11: Current-limit bit sets on limiting, latched until read with overcurrent gone.
// RL12: Per-channel summary bit is the OR of every fault type on that channel.
// RL13: On-state open-load bits clear on reading their own register, condition ended.
// RL14: Bits 7..4 of each status register read zero, untouched by reads.
package cfs_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int CH_NUM = 4;
   localparam int KIND_NUM = 4;
   localparam int REG_W = 8;
   localparam int IDX_W = 6;

   // ------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_SUMMARY = 6'h01;
   localparam logic [IDX_W-1:0] IDX_SHORT = 6'h03;
   localparam logic [IDX_W-1:0] IDX_OPEN_OFF = 6'h04;
   localparam logic [IDX_W-1:0] IDX_OPEN_ON = 6'h05;
   localparam logic [IDX_W-1:0] IDX_ILIMIT = 6'h06;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h10;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h11;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CH_NUM-1:0] RST_CH_STAT = 4'h0;
   localparam logic [KIND_NUM-1:0] RST_IRQ_STAT = 4'h0;
   localparam logic [KIND_NUM-1:0] RST_IRQ_MASK = 4'h0;

   // ------------------------------------------------------------
   // Fault kinds: position in the kind arrays and in interrupt bits
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CFS_K_SHORT,
      CFS_K_OPEN_OFF,
      CFS_K_OPEN_ON,
      CFS_K_ILIMIT
   } cfs_kind_e;

endpackage : cfs_pkg

// >>> pkg/cfs_evt_if.sv
// Link between the register front end and one latched status bank
`timescale 1ns/1ps
interface cfs_evt_if #(
   parameter int W = 4
);
   logic [W-1:0] cond;
   logic [W-1:0] clr_req;
   logic [W-1:0] stat;
   logic new_set;

   modport bank (
      input cond,
      input clr_req,
      output stat,
      output new_set
   );

   modport ctl (
      output cond,
      output clr_req,
      input stat,
      input new_set
   );
endinterface : cfs_evt_if

// >>> src/cfs_sync.sv
// Two-stage synchroniser for asynchronous fault condition inputs
`timescale 1ns/1ps
module cfs_sync #(
   parameter int W = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q_sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = d_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign q_sync = sync_r;
endmodule : cfs_sync

// >>> src/cfs_latch.sv
// Latched per-channel fault bits with clear on read once the condition is gone
`timescale 1ns/1ps
module cfs_latch #(
   parameter int W = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   cfs_evt_if.bank ev
);
   logic [W-1:0] stat_r;
   logic [W-1:0] stat_nxt;

   // ------------------------------------------------------------
   // Set wins over clear; a bit only clears while its condition is absent
   // ------------------------------------------------------------
   always_comb begin
      stat_nxt = (stat_r & ~(ev.clr_req & ~ev.cond)) | ev.cond; // RL2 RL5 RL11 RL13
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stat_r <= cfs_pkg::RST_CH_STAT; // RL10
      end else begin
         stat_r <= stat_nxt;
      end
   end

   assign ev.stat = stat_r;
   assign ev.new_set = |(ev.cond & ~stat_r);
endmodule : cfs_latch

// >>> src/cfs_top.sv
// Channel fault status register bank with APB slave and interrupt
`timescale 1ns/1ps
module cfs_top #(
   parameter int CH = cfs_pkg::CH_NUM
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CH-1:0] short_to_supply_ch_bit,
   input wire logic [CH-1:0] open_load_off_ch_bit,
   input wire logic [CH-1:0] open_load_on_ch_bit,
   input wire logic [CH-1:0] current_limit_ch_bit,
   input wire logic [CH-1:0] thermal_sd_ch_bit,
   input wire logic [CH-1:0] reverse_block_ch_bit,
   output logic [CH-1:0] channel_fault_summary,
   output logic irq
);
   localparam int KN = cfs_pkg::KIND_NUM;
   localparam int SW = 6 * CH;

   // ------------------------------------------------------------
   // Synchronise the fault conditions
   // ------------------------------------------------------------
   logic [SW-1:0] cond_raw;
   logic [SW-1:0] cond_sync;
   logic [CH-1:0] cond_k [KN];
   logic [CH-1:0] thermal_s;
   logic [CH-1:0] reverse_s;

   assign cond_raw = {reverse_block_ch_bit, thermal_sd_ch_bit, current_limit_ch_bit,
                      open_load_on_ch_bit, open_load_off_ch_bit, short_to_supply_ch_bit};

   cfs_sync #(
      .W(SW)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d_async(cond_raw),
      .q_sync(cond_sync)
   );

   assign thermal_s = cond_sync[4*CH +: CH];
   assign reverse_s = cond_sync[5*CH +: CH];

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic [cfs_pkg::IDX_W-1:0] idx;
   logic setup_ph;
   logic rd_acc;
   logic wr_acc;
   logic hit_short;
   logic hit_open_off;
   logic hit_open_on;
   logic hit_ilimit;
   logic hit_summary;
   logic hit_irq_stat;
   logic hit_irq_mask;
   logic hit_any;

   assign idx = paddr[7:2];
   assign setup_ph = psel & ~penable;
   assign rd_acc = psel & penable & pready & ~pwrite;
   assign wr_acc = psel & penable & pready & pwrite;

   always_comb begin
      hit_short = 1'b0;
      hit_open_off = 1'b0;
      hit_open_on = 1'b0;
      hit_ilimit = 1'b0;
      hit_summary = 1'b0;
      hit_irq_stat = 1'b0;
      hit_irq_mask = 1'b0;
      if (idx == cfs_pkg::IDX_SHORT) begin
         hit_short = 1'b1; // RL1
      end else if (idx == cfs_pkg::IDX_OPEN_OFF) begin
         hit_open_off = 1'b1; // RL4
      end else if (idx == cfs_pkg::IDX_OPEN_ON) begin
         hit_open_on = 1'b1; // RL7
      end else if (idx == cfs_pkg::IDX_ILIMIT) begin
         hit_ilimit = 1'b1; // RL9
      end else if (idx == cfs_pkg::IDX_SUMMARY) begin
         hit_summary = 1'b1;
      end else if (idx == cfs_pkg::IDX_IRQ_STAT) begin
         hit_irq_stat = 1'b1;
      end else if (idx == cfs_pkg::IDX_IRQ_MASK) begin
         hit_irq_mask = 1'b1;
      end
   end

   assign hit_any = hit_short | hit_open_off | hit_open_on | hit_ilimit |
                    hit_summary | hit_irq_stat | hit_irq_mask;

   // ------------------------------------------------------------
   // Latched status banks, one per fault kind
   // ------------------------------------------------------------
   logic [KN-1:0] hit_k;
   logic [CH-1:0] stat_k [KN];
   logic [KN-1:0] new_set_k;
   logic [CH-1:0] snap_r;
   logic [CH-1:0] snap_nxt;

   assign hit_k = {hit_ilimit, hit_open_on, hit_open_off, hit_short};

   genvar gk;
   generate
      for (gk = 0; gk < KN; gk++) begin : g_kind
         cfs_evt_if #(
            .W(CH)
         ) u_ev ();

         assign cond_k[gk] = cond_sync[gk*CH +: CH];
         assign u_ev.cond = cond_k[gk];
         // Only bits already returned to software may be cleared by this read
         assign u_ev.clr_req = (rd_acc & hit_k[gk]) ? snap_r : '0; // RL2 RL5 RL11 RL13
         assign stat_k[gk] = u_ev.stat;
         assign new_set_k[gk] = u_ev.new_set;

         cfs_latch #(
            .W(CH)
         ) u_latch (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .ev(u_ev.bank)
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Channel summary
   // ------------------------------------------------------------
   logic [CH-1:0] summary_r;
   logic [CH-1:0] summary_nxt;

   always_comb begin
      summary_nxt = thermal_s | reverse_s; // RL12
      for (int k = 0; k < KN; k++) begin
         summary_nxt = summary_nxt | stat_k[k]; // RL12
      end
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [KN-1:0] irq_stat_r;
   logic [KN-1:0] irq_stat_nxt;
   logic [KN-1:0] irq_mask_r;
   logic [KN-1:0] irq_mask_nxt;
   logic irq_r;
   logic irq_nxt;

   always_comb begin
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      if (wr_acc && hit_irq_stat) begin
         irq_stat_nxt = irq_stat_r & ~pwdata[KN-1:0];
      end
      if (wr_acc && hit_irq_mask) begin
         irq_mask_nxt = pwdata[KN-1:0];
      end
      // New fault events win over a same-cycle clear
      irq_stat_nxt = irq_stat_nxt | new_set_k;
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   // ------------------------------------------------------------
   // Read data, ready and error, all prepared in the setup cycle
   // ------------------------------------------------------------
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;

   always_comb begin
      prdata_nxt = prdata_r;
      snap_nxt = snap_r;
      pready_nxt = setup_ph;
      pslverr_nxt = setup_ph & ~hit_any;
      if (setup_ph) begin
         prdata_nxt = 32'h0000_0000; // RL14
         if (!pwrite) begin
            if (hit_short) begin
               prdata_nxt[CH-1:0] = stat_k[cfs_pkg::CFS_K_SHORT]; // RL3
            end else if (hit_open_off) begin
               prdata_nxt[CH-1:0] = stat_k[cfs_pkg::CFS_K_OPEN_OFF]; // RL6
            end else if (hit_open_on) begin
               prdata_nxt[CH-1:0] = stat_k[cfs_pkg::CFS_K_OPEN_ON]; // RL8
            end else if (hit_ilimit) begin
               prdata_nxt[CH-1:0] = stat_k[cfs_pkg::CFS_K_ILIMIT]; // RL9
            end else if (hit_summary) begin
               prdata_nxt[CH-1:0] = summary_r;
            end else if (hit_irq_stat) begin
               prdata_nxt[KN-1:0] = irq_stat_r;
            end else if (hit_irq_mask) begin
               prdata_nxt[KN-1:0] = irq_mask_r;
            end
         end
         snap_nxt = prdata_nxt[CH-1:0];
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prdata_r <= 32'h0000_0000;
         snap_r <= cfs_pkg::RST_CH_STAT;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         summary_r <= cfs_pkg::RST_CH_STAT;
         irq_stat_r <= cfs_pkg::RST_IRQ_STAT;
         irq_mask_r <= cfs_pkg::RST_IRQ_MASK;
         irq_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         snap_r <= snap_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         summary_r <= summary_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign channel_fault_summary = summary_r;
   assign irq = irq_r;
endmodule : cfs_top

// >>> test/cfs_top_sva.sv
// Port-level checks of the fault status register bank
`timescale 1ns/1ps
module cfs_top_sva #(
   parameter int CH = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CH-1:0] short_to_supply_ch_bit,
   input wire logic [CH-1:0] thermal_sd_ch_bit,
   input wire logic [CH-1:0] channel_fault_summary,
   input wire logic irq
);
   logic mapped;
   assign mapped = paddr[7:2] inside {cfs_pkg::IDX_SUMMARY, cfs_pkg::IDX_SHORT,
      cfs_pkg::IDX_OPEN_OFF, cfs_pkg::IDX_OPEN_ON, cfs_pkg::IDX_ILIMIT,
      cfs_pkg::IDX_IRQ_STAT, cfs_pkg::IDX_IRQ_MASK};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence short_held_s;
      short_to_supply_ch_bit[3] [*3];
   endsequence
   sequence therm_held_s;
      thermal_sd_ch_bit[1] [*3];
   endsequence
   setup_ready_a: assert property (setup_s |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_map_a: assert property (pready |-> pslverr == !mapped)
      else $error("error flag does not match map");
   err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("data on refused access");
   resv_zero_a: assert property (pready |-> prdata[31:4] == 28'h0)
      else $error("reserved bits not zero");
   rst_quiet_a: assert property (disable iff (1'b0) !rstn |=> prdata == 32'h0
      && !pready && !irq && channel_fault_summary == '0)
      else $error("outputs not cleared by reset");
   irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
      else $error("interrupt dropped without a write");
   summ_short_a: assert property (short_held_s |-> ##[1:3] channel_fault_summary[3])
      else $error("short missing from summary");
   summ_therm_a: assert property (therm_held_s |-> ##[1:3] channel_fault_summary[1])
      else $error("thermal missing from summary");
endmodule : cfs_top_sva
bind cfs_top cfs_top_sva #(.CH(CH)) i_sva (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .short_to_supply_ch_bit(short_to_supply_ch_bit),
   .thermal_sd_ch_bit(thermal_sd_ch_bit), .channel_fault_summary(channel_fault_summary),
   .irq(irq));

// >>> test/cfs_fault_src.sv
// Channel fault conditions as the switch stages would raise them
`timescale 1ns/1ps
module cfs_fault_src (
   input wire logic clk_sys,
   output logic [23:0] cond
);
   initial cond = 24'h0;
   // Kind k: 0 short, 1 open off, 2 open on, 3 limit, 4 thermal, 5 reverse
   task automatic drive(input int k, input logic [3:0] m);
      @(posedge clk_sys);
      cond[4*k +: 4] <= m;
   endtask : drive
endmodule : cfs_fault_src

// >>> test/testbench.sv
// Self-checking bench for the channel fault status register bank
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic e;
   } cfs_row_s;
   localparam cfs_row_s ROWS [9] = '{'{8'h04, 32'h0, 1'b0}, '{8'h0c, 32'h0, 1'b0},
      '{8'h10, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b0},
      '{8'h40, 32'h0, 1'b0}, '{8'h44, 32'h0, 1'b0}, '{8'h08, 32'h0, 1'b1},
      '{8'h1c, 32'h0, 1'b1}};
   logic clk_sys = 1'b0;
   logic rstn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [7:0] paddr, a;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] summ;
   wire logic [23:0] cond;
   int failures = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   cfs_fault_src i_src (.clk_sys(clk_sys), .cond(cond));
   cfs_top #(.CH(4)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .short_to_supply_ch_bit(cond[3:0]),
      .open_load_off_ch_bit(cond[7:4]), .open_load_on_ch_bit(cond[11:8]),
      .current_limit_ch_bit(cond[15:12]), .thermal_sd_ch_bit(cond[19:16]),
      .reverse_block_ch_bit(cond[23:20]), .channel_fault_summary(summ), .irq(irq));
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   task automatic end_of_test();
      if (failures == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] ed, input logic ee);
      apb(1'b0, ad, 32'h0, rd, er);
      `CHK(rd, ed)
      `CHK(er, ee)
   endtask : rdchk
   initial begin
      wt(4000);
      failures++;
      end_of_test();
   end
   initial begin
      rstn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h0;
      pwdata <= 32'h0;
      wt(12);
      rstn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rdchk(ROWS[i].a, ROWS[i].d, ROWS[i].e);
      end
      for (int k = 0; k < 4; k++) begin
         a = 8'h0c + 8'(4 * k);
         i_src.drive(k, 4'h9);
         wt(4);
         i_src.drive(k, 4'h0);
         wt(5);
         `CHK(summ, 4'h9)
         rdchk(8'h04, 32'h9, 1'b0);
         rdchk(a, 32'h9, 1'b0);
         rdchk(a, 32'h0, 1'b0);
         rdchk(8'h40, 32'h1 << k, 1'b0);
         apb(1'b1, 8'h40, 32'hf, rd, er);
      end
      i_src.drive(0, 4'h4);
      wt(5);
      rdchk(8'h0c, 32'h4, 1'b0);
      rdchk(8'h0c, 32'h4, 1'b0);
      i_src.drive(0, 4'h0);
      wt(5);
      `CHK(irq, 1'b0)
      apb(1'b1, 8'h44, 32'h1, rd, er);
      wt(1);
      `CHK(irq, 1'b1)
      rdchk(8'h44, 32'h1, 1'b0);
      apb(1'b1, 8'h44, 32'h0, rd, er);
      wt(1);
      `CHK(irq, 1'b0)
      apb(1'b1, 8'h44, 32'h1, rd, er);
      apb(1'b1, 8'h40, 32'h1, rd, er);
      wt(1);
      `CHK(irq, 1'b0)
      rdchk(8'h0c, 32'h4, 1'b0);
      rdchk(8'h0c, 32'h0, 1'b0);
      apb(1'b1, 8'h0c, 32'hff, rd, er);
      `CHK(er, 1'b0)
      rdchk(8'h0c, 32'h0, 1'b0);
      i_src.drive(4, 4'h2);
      i_src.drive(5, 4'h8);
      wt(5);
      `CHK(summ, 4'ha)
      i_src.drive(4, 4'h0);
      i_src.drive(5, 4'h0);
      wt(5);
      `CHK(summ, 4'h0)
      i_src.drive(3, 4'h1);
      wt(4);
      i_src.drive(3, 4'h0);
      wt(5);
      rstn <= 1'b0;
      wt(2);
      rstn <= 1'b1;
      `CHK(summ, 4'h0)
      rdchk(8'h18, 32'h0, 1'b0);
      rdchk(8'h44, 32'h0, 1'b0);
      end_of_test();
   end
endmodule : testbench
